// >>> logic/dcpg_top.sv
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
module dcpg_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic start_trig_in,
  input wire logic enable_in,
  input wire logic protect_in,
  output logic [3:0] pwm_out,
  output logic adc_soc,
  output logic task_trig
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: start, enable, protection.
  logic [2:0] sync1_q, sync2_q;
  logic start_prev_q;
  logic start_s, en_s, prot_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      start_prev_q <= 1'b0;
    end else begin
      sync1_q <= {protect_in, enable_in, start_trig_in};
      sync2_q <= sync1_q;
      start_prev_q <= sync2_q[0];
    end
  end

  assign start_s = sync2_q[0] & ~start_prev_q;
  assign en_s = sync2_q[1];
  assign prot_s = sync2_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave and register file.
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_d, rvalid_d, awready_d, wready_d, arready_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic [31:0] ctrl_q, ctrl_d, chcfg_q, chcfg_d, period_q, period_d, fscale_q, fscale_d;
  logic [31:0] mi_q [2];
  logic [31:0] mi_d [2];
  logic [31:0] dead_q [2];
  logic [31:0] dead_d [2];
  logic [31:0] trig_q, trig_d;
  logic [32:0] rd_sel, wr_sel;
  logic [31:0] merged, bmask, status;
  logic commit, sw_start, sw_stop, force_out;
  dcpg_pkg::dcpg_cstate_t cstate_q, cstate_d;
  logic [23:0] acc_q, acc_d;

  // Returns {mapped, word} for a register byte address.
  function automatic logic [32:0] reg_word(input logic [7:0] a);
    unique case (a)
      dcpg_pkg::ADDR_CTRL: reg_word = {1'b1, ctrl_q};
      dcpg_pkg::ADDR_CHCFG: reg_word = {1'b1, chcfg_q};
      dcpg_pkg::ADDR_PERIOD: reg_word = {1'b1, period_q};
      dcpg_pkg::ADDR_MI0: reg_word = {1'b1, mi_q[0]};
      dcpg_pkg::ADDR_MI1: reg_word = {1'b1, mi_q[1]};
      dcpg_pkg::ADDR_FSCALE: reg_word = {1'b1, fscale_q};
      dcpg_pkg::ADDR_DEAD0: reg_word = {1'b1, dead_q[0]};
      dcpg_pkg::ADDR_DEAD1: reg_word = {1'b1, dead_q[1]};
      dcpg_pkg::ADDR_TRIG: reg_word = {1'b1, trig_q};
      dcpg_pkg::ADDR_STATUS: reg_word = {1'b1, status};
      default: reg_word = 33'h0_0000_0000;
    endcase
  endfunction

  assign status = {acc_q[23:8], 13'h0000, force_out, cstate_q == dcpg_pkg::CS_DOWN, cstate_q != dcpg_pkg::CS_IDLE};

  always_comb begin
    rd_sel = reg_word(araddr);
    wr_sel = reg_word(awaddr_q);
    bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    merged = (wr_sel[31:0] & ~bmask) | (wdata_q & bmask);
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid && !bready;
    bresp_d = bresp;
    rvalid_d = rvalid && !rready;
    rresp_d = rresp;
    rdata_d = rdata;
    if (awvalid && awready) begin
      aw_have_d = 1'b1;
      awaddr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_have_d = 1'b1;
      wdata_d = wdata;
      wstrb_d = wstrb;
    end
    commit = aw_have_q && w_have_q && !bvalid;
    if (commit) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_sel[32] ? dcpg_pkg::RESP_OKAY : dcpg_pkg::RESP_SLVERR;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rdata_d = rd_sel[31:0];
      rresp_d = rd_sel[32] ? dcpg_pkg::RESP_OKAY : dcpg_pkg::RESP_SLVERR;
    end
    awready_d = !aw_have_d;
    wready_d = !w_have_d;
    arready_d = !rvalid_d;
    ctrl_d = ctrl_q;
    chcfg_d = chcfg_q;
    period_d = period_q;
    fscale_d = fscale_q;
    trig_d = trig_q;
    mi_d = mi_q;
    dead_d = dead_q;
    sw_start = 1'b0;
    sw_stop = 1'b0;
    if (commit) begin
      unique case (awaddr_q)
        dcpg_pkg::ADDR_CTRL: begin
          ctrl_d = merged & dcpg_pkg::CTRL_MASK;
          sw_start = merged[dcpg_pkg::CTRL_START_BIT] & wstrb_q[0];
          sw_stop = merged[dcpg_pkg::CTRL_STOP_BIT] & wstrb_q[0];
        end
        dcpg_pkg::ADDR_CHCFG: chcfg_d = merged & dcpg_pkg::CHCFG_MASK;
        dcpg_pkg::ADDR_PERIOD: period_d = merged & dcpg_pkg::HALF_MASK;
        dcpg_pkg::ADDR_MI0: mi_d[0] = merged & dcpg_pkg::HALF_MASK;
        dcpg_pkg::ADDR_MI1: mi_d[1] = merged & dcpg_pkg::HALF_MASK;
        dcpg_pkg::ADDR_FSCALE: fscale_d = merged & dcpg_pkg::HALF_MASK;
        dcpg_pkg::ADDR_DEAD0: dead_d[0] = merged & dcpg_pkg::HALF_MASK;
        dcpg_pkg::ADDR_DEAD1: dead_d[1] = merged & dcpg_pkg::HALF_MASK;
        dcpg_pkg::ADDR_TRIG: trig_d = merged & dcpg_pkg::TRIG_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      rvalid <= 1'b0;
      rresp <= 2'b00;
      rdata <= 32'h0000_0000;
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
      ctrl_q <= dcpg_pkg::CTRL_RST;
      chcfg_q <= dcpg_pkg::CHCFG_RST;
      period_q <= dcpg_pkg::PERIOD_RST;
      fscale_q <= dcpg_pkg::FSCALE_RST;
      trig_q <= dcpg_pkg::TRIG_RST;
      mi_q <= '{32'h0000_0000, 32'h0000_0000};
      dead_q <= '{dcpg_pkg::DEAD_RST, dcpg_pkg::DEAD_RST};
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid <= bvalid_d;
      bresp <= bresp_d;
      rvalid <= rvalid_d;
      rresp <= rresp_d;
      rdata <= rdata_d;
      awready <= awready_d;
      wready <= wready_d;
      arready <= arready_d;
      ctrl_q <= ctrl_d;
      chcfg_q <= chcfg_d;
      period_q <= period_d;
      fscale_q <= fscale_d;
      trig_q <= trig_d;
      mi_q <= mi_d;
      dead_q <= dead_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Common carrier. The phase accumulator carries eight fraction bits so that
  // a scale below one still advances; a scale of zero freezes the carrier.
  dcpg_pkg::dcpg_evt_t ev_q, ev_d;
  logic [23:0] top, nxt_up;
  logic [24:0] sum;
  logic [15:0] step;
  logic sym, start_evt;

  always_comb begin
    sym = ctrl_q[dcpg_pkg::CTRL_SYM_BIT];
    top = {period_q[15:0], 8'h00};
    step = ctrl_q[dcpg_pkg::CTRL_FVAR_BIT] ? fscale_q[15:0] : dcpg_pkg::STEP_UNITY;
    sum = {1'b0, acc_q} + {9'h000, step};
    nxt_up = sum[23:0];
    start_evt = start_s | sw_start;
    cstate_d = cstate_q;
    acc_d = acc_q;
    ev_d = '{ov: 1'b0, uf: 1'b0};
    unique case (cstate_q)
      dcpg_pkg::CS_IDLE: begin
        acc_d = 24'h00_0000;
        if (start_evt) begin
          cstate_d = dcpg_pkg::CS_UP;
        end
      end
      dcpg_pkg::CS_UP: begin
        if (sum >= {1'b0, top}) begin
          ev_d.ov = 1'b1;
          if (sym) begin
            acc_d = top;
            cstate_d = dcpg_pkg::CS_DOWN;
          end else begin
            acc_d = 24'h00_0000;
            ev_d.uf = 1'b1;
          end
        end else begin
          acc_d = nxt_up;
        end
      end
      dcpg_pkg::CS_DOWN: begin
        if (acc_q <= {8'h00, step}) begin
          acc_d = 24'h00_0000;
          ev_d.uf = 1'b1;
          cstate_d = dcpg_pkg::CS_UP;
        end else begin
          acc_d = acc_q - {8'h00, step};
        end
      end
      default: begin
        cstate_d = dcpg_pkg::CS_IDLE;
        acc_d = 24'h00_0000;
      end
    endcase
    if (sw_stop) begin
      cstate_d = dcpg_pkg::CS_IDLE;
      acc_d = 24'h00_0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cstate_q <= dcpg_pkg::CS_IDLE;
      acc_q <= 24'h00_0000;
      ev_q <= '{ov: 1'b0, uf: 1'b0};
    end else begin
      cstate_q <= cstate_d;
      acc_q <= acc_d;
      ev_q <= ev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare channels and output stage.
  logic [1:0] act;
  logic [15:0] cmp [2];
  logic [3:0] pwm_w, passive_vec;
  dcpg_pkg::dcpg_chcfg_t chcfg [2];

  // A stopped carrier also forces the passive state, so a pair never idles with its low side on.
  assign force_out = (ctrl_q[dcpg_pkg::CTRL_ENUSE_BIT] & ~en_s)
                   | (ctrl_q[dcpg_pkg::CTRL_PROT_BIT] & prot_s)
                   | (cstate_q == dcpg_pkg::CS_IDLE);

  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [31:0] prod;
    assign chcfg[i] = dcpg_pkg::dcpg_chcfg_t'(chcfg_q[dcpg_pkg::CHCFG_STRIDE * i +: 3]);
    assign prod = mi_q[i][15:0] * period_q[15:0];
    assign cmp[i] = prod[31:16];
    assign act[i] = cmp[i] > acc_q[23:dcpg_pkg::CARR_FRAC];
    assign passive_vec[2 * i +: 2] = {2{~chcfg[i].pol}};
    dcpg_deadtime u_dt (
      .aclk(aclk),
      .aresetn(aresetn),
      .act(act[i]),
      .force_passive(force_out),
      .cfg(chcfg[i]),
      .dead_time_vector_in(dcpg_pkg::dcpg_dead_t'(dead_q[i][15:0])),
      .pwm(pwm_w[2 * i +: 2])
    );
  end

  assign pwm_out = pwm_w;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger dividers.
  dcpg_trigdiv u_adc (
    .aclk(aclk),
    .aresetn(aresetn),
    .evt(ev_q),
    .sel(dcpg_pkg::dcpg_evsel_t'(trig_q[dcpg_pkg::TRIG_ADC_SEL_LSB +: 2])),
    .div(trig_q[dcpg_pkg::TRIG_ADC_DIV_LSB +: 8]),
    .trig(adc_soc)
  );

  dcpg_trigdiv u_task (
    .aclk(aclk),
    .aresetn(aresetn),
    .evt(ev_q),
    .sel(dcpg_pkg::dcpg_evsel_t'(trig_q[dcpg_pkg::TRIG_TASK_SEL_LSB +: 2])),
    .div(trig_q[dcpg_pkg::TRIG_TASK_DIV_LSB +: 8]),
    .trig(task_trig)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_forced;
    force_out ##1 $stable(chcfg_q);
  endsequence

  a_carrier_held: assert property (cstate_q == dcpg_pkg::CS_IDLE && !start_evt |=> acc_q == 24'h00_0000 && ev_q == 2'b00)
    else $error("carrier moved before start");
  a_start_runs: assert property (cstate_q == dcpg_pkg::CS_IDLE && start_evt && !sw_stop |=> cstate_q == dcpg_pkg::CS_UP)
    else $error("start trigger ignored");
  a_uf_at_zero: assert property (ev_q.uf |-> acc_q == 24'h00_0000)
    else $error("underflow away from minimum");
  a_ov_at_top: assert property (ev_q.ov && cstate_q == dcpg_pkg::CS_DOWN && $stable(period_q) |-> acc_q == top)
    else $error("overflow away from maximum");
  a_saw_wrap: assert property (cstate_q == dcpg_pkg::CS_UP && !sym && !sw_stop && sum >= {1'b0, top}
    |=> ev_q == 2'b11 && acc_q == 24'h00_0000 ##1 cstate_q == dcpg_pkg::CS_UP)
    else $error("sawtooth wrap wrong");
  a_scaled_step: assert property (cstate_q == dcpg_pkg::CS_UP && !sw_stop && sum < {1'b0, top} |=> acc_q == $past(nxt_up))
    else $error("carrier step not scaled");
  a_forced_passive: assert property (s_forced |-> pwm_out == passive_vec)
    else $error("outputs not passive when forced");
  a_pair_no_overlap: assert property (chcfg[0].comp && $stable(chcfg_q) |-> !(pwm_out[0] == chcfg[0].pol && pwm_out[1] == chcfg[0].pol))
    else $error("pair active together");
  a_trig_source: assert property (adc_soc |-> $past(ev_q.ov) || $past(ev_q.uf))
    else $error("trigger without carrier event");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");

endmodule // dcpg_top

// >>> include/dcpg_pkg.sv
package dcpg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_PERIOD_NS = 50;
  localparam int DT_MIN_NS = 50;
  localparam logic [7:0] DT_MIN_CYC = 8'((DT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHCFG = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_MI0 = 8'h0c;
  localparam logic [7:0] ADDR_MI1 = 8'h10;
  localparam logic [7:0] ADDR_FSCALE = 8'h14;
  localparam logic [7:0] ADDR_DEAD0 = 8'h18;
  localparam logic [7:0] ADDR_DEAD1 = 8'h1c;
  localparam logic [7:0] ADDR_TRIG = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;

  // Field positions.
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_SYM_BIT = 2;
  localparam int CTRL_FVAR_BIT = 3;
  localparam int CTRL_ENUSE_BIT = 4;
  localparam int CTRL_PROT_BIT = 5;
  localparam int CHCFG_STRIDE = 4;
  localparam int TRIG_ADC_SEL_LSB = 0;
  localparam int TRIG_ADC_DIV_LSB = 8;
  localparam int TRIG_TASK_SEL_LSB = 16;
  localparam int TRIG_TASK_DIV_LSB = 24;
  localparam int CARR_FRAC = 8;

  // Masks and reset values.
  localparam logic [31:0] CTRL_MASK = 32'h0000_003c;
  localparam logic [31:0] CHCFG_MASK = 32'h0000_0077;
  localparam logic [31:0] HALF_MASK = 32'h0000_ffff;
  localparam logic [31:0] TRIG_MASK = 32'hff03_ff03;
  localparam logic [31:0] CTRL_RST = 32'h0000_0004;
  localparam logic [31:0] CHCFG_RST = 32'h0000_0055;
  localparam logic [31:0] PERIOD_RST = 32'h0000_03e8;
  localparam logic [31:0] FSCALE_RST = 32'h0000_0100;
  localparam logic [31:0] DEAD_RST = 32'h0000_0a0a;
  localparam logic [31:0] TRIG_RST = 32'h0101_0101;
  localparam logic [15:0] STEP_UNITY = 16'h0100;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [1:0] {
    EV_UNDER = 2'b00,
    EV_OVER = 2'b01,
    EV_BOTH = 2'b10
  } dcpg_evsel_t;

  typedef enum logic [2:0] {
    CS_IDLE = 3'b001,
    CS_UP = 3'b010,
    CS_DOWN = 3'b100
  } dcpg_cstate_t;

  typedef struct packed {
    logic pol;
    logic outsel;
    logic comp;
  } dcpg_chcfg_t;

  typedef struct packed {
    logic [7:0] fall;
    logic [7:0] rise;
  } dcpg_dead_t;

  typedef struct packed {
    logic ov;
    logic uf;
  } dcpg_evt_t;

endpackage

// >>> logic/dcpg_deadtime.sv
`timescale 1ns/1ns
module dcpg_deadtime (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic act,
  input wire logic force_passive,
  input wire dcpg_pkg::dcpg_chcfg_t cfg,
  input wire dcpg_pkg::dcpg_dead_t dead_time_vector_in,
  output logic [1:0] pwm
);

  logic act_q, act_d;
  logic [7:0] cnt_q, cnt_d;
  logic [1:0] pwm_d;
  logic [7:0] rise_c, fall_c;
  logic settled, passive;

  always_comb begin
    rise_c = (dead_time_vector_in.rise < dcpg_pkg::DT_MIN_CYC) ? dcpg_pkg::DT_MIN_CYC : dead_time_vector_in.rise;
    fall_c = (dead_time_vector_in.fall < dcpg_pkg::DT_MIN_CYC) ? dcpg_pkg::DT_MIN_CYC : dead_time_vector_in.fall;
    act_d = act;
    cnt_d = (cnt_q == 8'h00) ? 8'h00 : cnt_q - 8'h01;
    if (act != act_q) begin
      cnt_d = act ? rise_c : fall_c;
    end
    settled = (cnt_q == 8'h00);
    passive = ~cfg.pol;
    pwm_d = {passive, passive};
    if (!force_passive) begin
      if (cfg.comp) begin
        // Both outputs stay passive while the dead-time counter runs.
        pwm_d[0] = (act_q && settled) ? cfg.pol : passive;
        pwm_d[1] = (!act_q && settled) ? cfg.pol : passive;
      end else begin
        pwm_d[cfg.outsel] = act_q ? cfg.pol : passive;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_q <= 1'b0;
      cnt_q <= 8'h00;
      pwm <= 2'b00;
    end else begin
      act_q <= act_d;
      cnt_q <= cnt_d;
      pwm <= pwm_d;
    end
  end

endmodule // dcpg_deadtime

// >>> logic/dcpg_trigdiv.sv
`timescale 1ns/1ns
module dcpg_trigdiv (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dcpg_pkg::dcpg_evt_t evt,
  input wire dcpg_pkg::dcpg_evsel_t sel,
  input wire logic [7:0] div,
  output logic trig
);

  logic [7:0] cnt_q, cnt_d;
  logic trig_d, hit;

  always_comb begin
    unique case (sel)
      dcpg_pkg::EV_UNDER: hit = evt.uf;
      dcpg_pkg::EV_OVER: hit = evt.ov;
      dcpg_pkg::EV_BOTH: hit = evt.uf | evt.ov;
      default: hit = 1'b0;
    endcase
    cnt_d = cnt_q;
    trig_d = 1'b0;
    if (hit) begin
      // A divider of zero behaves as one.
      if (cnt_q + 8'h01 >= div) begin
        cnt_d = 8'h00;
        trig_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 8'h00;
      trig <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      trig <= trig_d;
    end
  end

endmodule // dcpg_trigdiv

// >>> verification/dcpg_gate_model.sv
`timescale 1ns/1ns
// Gate-driver and converter-trigger sink; it only listens, so it can never stall the block.
module dcpg_gate_model (
  input wire logic aclk,
  input wire logic clr,
  input wire logic [3:0] pwm,
  input wire logic adc_soc,
  input wire logic task_trig,
  output logic [3:0][15:0] hi_q,
  output logic [15:0] both_q,
  output logic [15:0] adc_gap_q,
  output logic [15:0] task_gap_q
);
  logic [15:0] adc_t_q;
  logic [15:0] task_t_q;

  //////////////////////////////////////////////////////////////////////////////
  // A cycle with both members of pair 0 high would short the half bridge, so it is counted apart.
  always_ff @(posedge aclk) begin
    if (clr) begin
      hi_q <= '0;
      both_q <= '0;
      adc_t_q <= '0;
      task_t_q <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        hi_q[i] <= hi_q[i] + 16'(pwm[i]);
      end
      both_q <= both_q + 16'(pwm[0] & pwm[1]);
      adc_t_q <= adc_soc ? 16'h0001 : adc_t_q + 16'h0001;
      task_t_q <= task_trig ? 16'h0001 : task_t_q + 16'h0001;
      if (adc_soc) begin
        adc_gap_q <= adc_t_q;
      end
      if (task_trig) begin
        task_gap_q <= task_t_q;
      end
    end
  end
endmodule // dcpg_gate_model

// >>> verification/dcpg_top_tb.sv
`timescale 1ns/1ns
module dcpg_top_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, start_trig_in, enable_in, protect_in;
  logic adc_soc, task_trig, clr;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, pwm_out;
  logic [1:0] bresp, rresp, rs;
  logic [3:0][15:0] hi;
  logic [15:0] both, adc_gap, task_gap, g1;
  int miscompares, n_compared;

  // One design instance owns its slice alone.
  dcpg_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .start_trig_in, .enable_in, .protect_in, .pwm_out, .adc_soc, .task_trig);
  dcpg_gate_model pm (.aclk, .clr, .pwm(pwm_out), .adc_soc, .task_trig, .hi_q(hi), .both_q(both),
    .adc_gap_q(adc_gap), .task_gap_q(task_gap));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits as long as the slave needs; only the watchdog ends a hung handshake.
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (awvalid || wvalid || !bvalid) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (arvalid || !rvalid) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // Clears the gate model's counts and timers, then lets it sample exactly cyc cycles.
  task automatic win(input int cyc);
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (cyc) @(posedge aclk);
    #1;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    axr(dcpg_pkg::ADDR_CTRL);
    chk(rd, dcpg_pkg::CTRL_RST);
    axr(dcpg_pkg::ADDR_CHCFG);
    chk(rd, dcpg_pkg::CHCFG_RST);
    axr(dcpg_pkg::ADDR_TRIG);
    chk(rd, dcpg_pkg::TRIG_RST);
    axr(8'h28);
    chk(rd, 32'h0);
    chk(32'(rs), 32'(dcpg_pkg::RESP_SLVERR));
    axw(8'h28, 32'hffff_ffff, dcpg_pkg::RESP_SLVERR);
    axw(dcpg_pkg::ADDR_PERIOD, 32'h14, dcpg_pkg::RESP_OKAY);
    axr(dcpg_pkg::ADDR_PERIOD);
    chk(rd, 32'h14);
    win(60);
    chk(32'(hi[0] | hi[1] | hi[2] | hi[3]), 32'h0);
    axr(dcpg_pkg::ADDR_STATUS);
    chk(32'(rd[0]), 32'h0);
  endtask

  // Half index on channel 0, zero on channel 1, symmetrical carrier of 20 steps each way.
  task automatic t_run;
    axw(dcpg_pkg::ADDR_MI0, 32'h8000, dcpg_pkg::RESP_OKAY);
    axw(dcpg_pkg::ADDR_MI1, 32'h0, dcpg_pkg::RESP_OKAY);
    axw(dcpg_pkg::ADDR_DEAD0, 32'h0101, dcpg_pkg::RESP_OKAY);
    axw(dcpg_pkg::ADDR_TRIG, 32'h0102_0200, dcpg_pkg::RESP_OKAY);
    start_trig_in <= 1'b1;
    repeat (4) @(posedge aclk);
    start_trig_in <= 1'b0;
    repeat (40) @(posedge aclk);
    axr(dcpg_pkg::ADDR_STATUS);
    chk(32'(rd[0]), 32'h1);
    win(400);
    chk(32'(hi[2]), 32'h0);
    chk(32'(hi[3]), 32'h190);
    chk(32'(hi[0] > 16'd160 && hi[0] <= 16'd200), 32'h1);
    chk(32'(hi[1] > 16'd160 && hi[1] < 16'd210), 32'h1);
    chk(32'(both), 32'h0);
    chk(32'(hi[0] + hi[1] < 16'd400), 32'h1);
    chk(32'(adc_gap), 32'(task_gap) * 4);
    g1 = task_gap;
  endtask

  task automatic t_freq;
    axw(dcpg_pkg::ADDR_FSCALE, 32'h200, dcpg_pkg::RESP_OKAY);
    axw(dcpg_pkg::ADDR_CTRL, 32'hc, dcpg_pkg::RESP_OKAY);
    win(200);
    chk(32'(task_gap) * 2, 32'(g1));
    axw(dcpg_pkg::ADDR_CTRL, 32'h4, dcpg_pkg::RESP_OKAY);
    win(200);
    chk(32'(task_gap), 32'(g1));
  endtask

  task automatic t_saw;
    axw(dcpg_pkg::ADDR_TRIG, 32'h0301_0101, dcpg_pkg::RESP_OKAY);
    axw(dcpg_pkg::ADDR_CTRL, 32'h0, dcpg_pkg::RESP_OKAY);
    win(400);
    chk(32'(task_gap), 32'(adc_gap) * 3);
    chk(32'(adc_gap < 16'd30), 32'h1);
    axw(dcpg_pkg::ADDR_CTRL, 32'h4, dcpg_pkg::RESP_OKAY);
  endtask

  task automatic t_force;
    axw(dcpg_pkg::ADDR_CTRL, 32'h14, dcpg_pkg::RESP_OKAY);
    enable_in <= 1'b0;
    repeat (8) @(posedge aclk);
    win(100);
    chk(32'(hi[0] | hi[1] | hi[2] | hi[3]), 32'h0);
    @(posedge aclk);
    enable_in <= 1'b1;
    axw(dcpg_pkg::ADDR_CTRL, 32'h24, dcpg_pkg::RESP_OKAY);
    protect_in <= 1'b1;
    repeat (8) @(posedge aclk);
    win(100);
    chk(32'(hi[0] | hi[1] | hi[2] | hi[3]), 32'h0);
    @(posedge aclk);
    protect_in <= 1'b0;
    repeat (8) @(posedge aclk);
    win(100);
    chk(32'(hi[0] != 16'h0), 32'h1);
  endtask

  task automatic t_cfg;
    axw(dcpg_pkg::ADDR_MI1, 32'hc000, dcpg_pkg::RESP_OKAY);
    axw(dcpg_pkg::ADDR_CHCFG, 32'h65, dcpg_pkg::RESP_OKAY);
    win(200);
    chk(32'(hi[2]), 32'h0);
    chk(32'(hi[3] > hi[0] + 16'd40), 32'h1);
    axw(dcpg_pkg::ADDR_CHCFG, 32'h25, dcpg_pkg::RESP_OKAY);
    win(200);
    chk(32'(hi[2]), 32'd200);
    chk(32'(hi[3] < 16'd80), 32'h1);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, start_trig_in, protect_in} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    enable_in = 1'b1;
    clr = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_run;
    t_freq;
    t_saw;
    t_force;
    t_cfg;
    test_done;
  end

  // The sequence needs about 2150 cycles; this limit is well beyond that.
  initial begin
    #1_000_000;
    miscompares++;
    test_done;
  end
endmodule // dcpg_top_tb
